/* File: src/hpr_pkg.sv */
// Purpose: shared types and constants for the host port ready logic
// Assumes: one 10 MHz system clock
// Notes:   access kinds come from the two control select pins
package hpr_pkg;

   // Access kinds selected by the two control pins
   typedef enum logic [1:0] {
      HPR_CTRL     = 2'h0,
      HPR_DATA_AI  = 2'h1,
      HPR_ADDR     = 2'h2,
      HPR_DATA_FIX = 2'h3
   } hpr_kind_t;

   // Select group sampled with the strobe
   typedef struct packed {
      hpr_kind_t kind;
      logic      read;
      logic      second;
   } hpr_sel_t;

   // Internal status from the FIFO side
   typedef struct packed {
      logic wr_full;
      logic wr_flush;
      logic wr_empty;
      logic rd_hit;
      logic rd_ahead;
   } hpr_fifo_t;

   localparam int        HPR_HALF_W    = 16;
   localparam logic      HPR_READY_RST = 1'h0;
   localparam logic [1:0] HPR_SYNC_RST = 2'h0;

endpackage : hpr_pkg

/* File: src/hpr_sync.sv */
// Purpose: two-flop synchroniser for one pin input
// Assumes: input is asynchronous to clk_in
// Notes:   first stage feeds only the second
`timescale 1ns/1ns
module hpr_sync (
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic d_in,
   input  wire logic rst_val_in,
   output logic      q_out
);
   logic [1:0] stage;
   logic [1:0] next_stage;

   // Shift the pin level in
   always_comb begin
      next_stage = {stage[0], d_in};
   end

   // Reset to idle-high pins so a reset does not fake a strobe
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stage <= 2'h3;
      end else begin
         stage <= next_stage;
      end
   end

   assign q_out = rst_val_in ? stage[1] : stage[1];
endmodule : hpr_sync

/* File: src/hpr_ready.sv */
// Purpose: ready handshake of a 16-bit parallel host port
// Assumes: pins pass two flops; FIFO status comes from same-clock logic
// Notes:   ready is active low; high means wait
`timescale 1ns/1ns
module hpr_ready (
   input  wire logic               clk_in,
   input  wire logic               rst_b_in,
   input  wire logic               host_chip_select_b_in,
   input  wire logic               host_data_strobe_one_b_in,
   input  wire logic               host_data_strobe_two_b_in,
   input  wire logic [1:0]         host_control_sel_in,
   input  wire logic               host_read_in,
   input  wire logic               half_word_select_in,
   input  wire hpr_pkg::hpr_fifo_t fifo_in,
   input  wire logic               fifo_busy_in,
   output logic                    host_ready_out,
   output logic                    data_now_out,
   output logic                    access_start_out,
   output logic                    word_done_out
);

   ////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic cs_b;
   logic ds1_b;
   logic ds2_b;
   logic [1:0] ctl;
   logic rd;
   logic hw;
   logic [5:0] pins;
   logic [5:0] pins_s;
   assign pins = {host_chip_select_b_in, host_data_strobe_one_b_in, host_data_strobe_two_b_in,
                  host_control_sel_in, host_read_in};

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_sync
         hpr_sync u_sync (
            .clk_in     (clk_in),
            .rst_b_in   (rst_b_in),
            .d_in       (pins[gi]),
            .rst_val_in (1'h1),
            .q_out      (pins_s[gi])
         );
      end
   endgenerate

   logic hw_s1;
   logic hw_s2;
   // Half-word select synchronised separately, same two flops
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hw_s1 <= 1'h0;
         hw_s2 <= 1'h0;
      end else begin
         hw_s1 <= half_word_select_in;
         hw_s2 <= hw_s1;
      end
   end
   assign {cs_b, ds1_b, ds2_b, ctl, rd} = pins_s;
   assign hw = hw_s2;

   ////////////////////////////////////////////////////////////////
   // Strobe forming
   logic strobe_b;
   assign strobe_b = ~(ds1_b ^ ds2_b) | cs_b;

   hpr_pkg::hpr_sel_t sel;
   assign sel = '{kind: hpr_pkg::hpr_kind_t'(ctl), read: rd, second: hw};

   ////////////////////////////////////////////////////////////////
   // Access tracking state
   typedef enum logic [1:0] {HPR_IDLE, HPR_WAIT, HPR_HOLD} hpr_state_t;
   hpr_state_t state;
   hpr_state_t next_state;
   logic last_addr_wr;
   logic next_last_addr_wr;
   logic second_q;
   logic next_second_q;
   logic ready_b;
   logic next_ready_b;
   logic now;
   logic next_now;
   logic start;
   logic next_start;
   logic done;
   logic next_done;
   logic need_wait;
   logic fast_read;

   // Wait decision for the access just opened
   always_comb begin
      need_wait = 1'h0;
      fast_read = 1'h0;
      case (sel.kind)
         hpr_pkg::HPR_ADDR: begin
            if (!sel.read) begin
               need_wait = last_addr_wr | fifo_in.rd_ahead;
            end else begin
               fast_read = 1'h1;
            end
         end
         hpr_pkg::HPR_CTRL: begin
            fast_read = sel.read;
         end
         hpr_pkg::HPR_DATA_AI: begin
            if (!sel.read) begin
               need_wait = fifo_in.wr_full | fifo_in.wr_flush | ~fifo_in.wr_empty;
            end else if (sel.second || fifo_in.rd_hit) begin
               fast_read = 1'h1;
            end else begin
               need_wait = 1'h1;
            end
         end
         hpr_pkg::HPR_DATA_FIX: begin
            if (!sel.read) begin
               need_wait = fifo_in.wr_full | fifo_in.wr_flush | ~fifo_in.wr_empty;
            end else if (sel.second) begin
               fast_read = 1'h1;
            end else begin
               need_wait = 1'h1;
            end
         end
         default: begin
            need_wait = 1'h0;
         end
      endcase
   end

   // Sequence: open access, wait for FIFO side, hold until strobe ends
   always_comb begin
      next_state        = state;
      next_last_addr_wr = last_addr_wr;
      next_second_q     = second_q;
      next_ready_b      = ready_b;
      next_now          = 1'h0;
      next_start        = 1'h0;
      next_done         = 1'h0;
      case (state)
         HPR_IDLE: begin
            if (!strobe_b) begin
               next_start        = 1'h1;
               next_now          = fast_read;
               next_last_addr_wr = (sel.kind == hpr_pkg::HPR_ADDR) && !sel.read;
               next_second_q     = sel.second;
               if (need_wait) begin
                  next_ready_b = 1'h1;
                  next_state   = HPR_WAIT;
               end else begin
                  next_state   = HPR_HOLD;
               end
            end
         end
         HPR_WAIT: begin
            // Host keeps strobe low meanwhile, so only the FIFO side or a deselect ends this
            if (!fifo_busy_in) begin
               next_ready_b = 1'h0;
               next_state   = HPR_HOLD;
            end
         end
         HPR_HOLD: begin
            // Half latched at open: host may move selects as the strobe rises
            if (strobe_b) begin
               next_done  = second_q;
               next_state = HPR_IDLE;
            end
         end
         default: begin
            next_state = HPR_IDLE;
         end
      endcase
      // Deselect always releases the host, whatever the FIFO says
      if (cs_b) begin
         next_ready_b = 1'h0;
         if (state == HPR_WAIT) begin
            next_state = HPR_IDLE;
         end
      end
   end

   // Register the sequence
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state        <= HPR_IDLE;
         last_addr_wr <= 1'h0;
         second_q     <= 1'h0;
         ready_b      <= hpr_pkg::HPR_READY_RST;
         now          <= 1'h0;
         start        <= 1'h0;
         done         <= 1'h0;
      end else begin
         state        <= next_state;
         last_addr_wr <= next_last_addr_wr;
         second_q     <= next_second_q;
         ready_b      <= next_ready_b;
         now          <= next_now;
         start        <= next_start;
         done         <= next_done;
      end
   end

   assign host_ready_out   = ready_b;
   assign data_now_out     = now;
   assign access_start_out = start;
   assign word_done_out    = done;

   ////////////////////////////////////////////////////////////////
   // Checks
   logic cs_b_d;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cs_b_d <= 1'h1;
      end else begin
         cs_b_d <= cs_b;
      end
   end

   deselect_ready_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      cs_b_d |-> !host_ready_out)
      else $error("ready not low while deselected");
   ctrl_read_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (state == HPR_IDLE && !strobe_b && !cs_b && sel.read && sel.kind == hpr_pkg::HPR_CTRL)
      |=> !host_ready_out && data_now_out)
      else $error("control read waited");
   fix_first_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (state == HPR_IDLE && !strobe_b && !cs_b && sel.read && !sel.second
       && sel.kind == hpr_pkg::HPR_DATA_FIX) |=> host_ready_out)
      else $error("fixed first half did not wait");
   hit_read_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (state == HPR_IDLE && !strobe_b && !cs_b && sel.read && fifo_in.rd_hit
       && sel.kind == hpr_pkg::HPR_DATA_AI) |=> !host_ready_out && data_now_out)
      else $error("hit read waited");
   data_write_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (state == HPR_IDLE && !strobe_b && !cs_b && !sel.read && fifo_in.wr_full
       && sel.kind == hpr_pkg::HPR_DATA_AI) |=> host_ready_out)
      else $error("write into full FIFO did not wait");
   addr_pair_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (state == HPR_IDLE && !strobe_b && !cs_b && !sel.read && !last_addr_wr && !fifo_in.rd_ahead
       && sel.kind == hpr_pkg::HPR_ADDR) |=> !host_ready_out)
      else $error("single address write waited");
   wait_release_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (state == HPR_WAIT && !fifo_busy_in && !cs_b) |=> !host_ready_out ##0 state == HPR_HOLD)
      else $error("wait did not release");
   strobe_form_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (state == HPR_IDLE && strobe_b) |=> !access_start_out)
      else $error("access without strobe");
   word_pair_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      word_done_out |-> $past(second_q))
      else $error("word done on first half");
   fast_data_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      data_now_out |-> access_start_out && !host_ready_out)
      else $error("immediate data with wait");

   cov_wait_c:  cover property (@(posedge clk_in) state == HPR_WAIT ##[1:20] state == HPR_HOLD);
   cov_word_c:  cover property (@(posedge clk_in) word_done_out);
   cov_desel_c: cover property (@(posedge clk_in) state == HPR_WAIT && cs_b);
endmodule : hpr_ready

/* File: test/hpr_host_model.sv */
// Purpose: host processor model driving the port pins
// Assumes: one access at a time, started by the bench
// Notes:   mode 0 normal, 1 both strobes low, 2 select high, 3 abort
`timescale 1ns/1ns
module hpr_host_model (
   input  wire logic  clk_in,
   input  wire logic  ready_in,
   output logic       cs_b_out,
   output logic       ds1_b_out,
   output logic       ds2_b_out,
   output logic [1:0] sel_out,
   output logic       rd_out,
   output logic       hws_out
);
   ////////////////////////////////////////////////////////////
   // Idle pin levels
   initial begin
      cs_b_out = 1'h1;
      ds1_b_out = 1'h1;
      ds2_b_out = 1'h1;
      sel_out = 2'h0;
      rd_out = 1'h0;
      hws_out = 1'h0;
   end
   ////////////////////////////////////////////////////////////
   // One half-word access
   task automatic access(input logic [1:0] k, input logic r, input logic s, input int mode);
      int n;
      @(posedge clk_in);
      #1;
      sel_out = k;
      rd_out = r;
      hws_out = s;
      cs_b_out = (mode == 2) ? 1'h1 : 1'h0;
      // Selects settle one cycle before the strobe
      @(posedge clk_in);
      #1;
      if (mode == 1 || $urandom % 2) ds1_b_out = 1'h0;
      if (mode == 1 || ds1_b_out) ds2_b_out = 1'h0;
      repeat (4) @(posedge clk_in);
      #1;
      n = 0;
      // Strobe held until ready is back low; abort skips the wait
      while (mode != 3 && ready_in !== 1'h0 && n < 40) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      cs_b_out = 1'h1;
      ds1_b_out = 1'h1;
      ds2_b_out = 1'h1;
      // Released selects no longer show the old value
      sel_out = ~k;
      rd_out = ~r;
      hws_out = ~s;
   endtask : access
endmodule : hpr_host_model

/* File: test/testbench.sv */
// Purpose: self-checking bench for the ready handshake
// Assumes: host model on the pins, bench plays the FIFO side
// Notes:   expected ready worked out per access from kind and FIFO state
`timescale 1ns/1ns
module testbench;
   logic               clk_in;
   logic               rst_b_in;
   logic               busy;
   hpr_pkg::hpr_fifo_t fifo;
   logic               cs_b, ds1_b, ds2_b, rd, hws, ready, now, start, done;
   logic [1:0]         sel;
   int                 err_count, n_compared, prev_aw;
   int                 n_done;
   // Count done pulses; a short access ends before run looks
   always @(posedge clk_in) begin
      if (done === 1'h1) n_done <= n_done + 1;
   end
   ////////////////////////////////////////////////////////////
   // Clock, 100 ns period
   initial begin
      clk_in = 1'h0;
      forever #50 clk_in = ~clk_in;
   end
   hpr_host_model u_host (.clk_in(clk_in), .ready_in(ready), .cs_b_out(cs_b), .ds1_b_out(ds1_b),
      .ds2_b_out(ds2_b), .sel_out(sel), .rd_out(rd), .hws_out(hws));
   hpr_ready u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .host_chip_select_b_in(cs_b),
      .host_data_strobe_one_b_in(ds1_b), .host_data_strobe_two_b_in(ds2_b), .host_control_sel_in(sel),
      .host_read_in(rd), .half_word_select_in(hws), .fifo_in(fifo), .fifo_busy_in(busy),
      .host_ready_out(ready), .data_now_out(now), .access_start_out(start), .word_done_out(done));
   ////////////////////////////////////////////////////////////
   // Reference model of the wait decision
   function automatic int exp_wait(int k, int r, int s, hpr_pkg::hpr_fifo_t f, int p);
      if (r) return (k == 1 && !s && !f.rd_hit) || (k == 3 && !s);
      if (k == 2) return p || f.rd_ahead;
      if (k == 1 || k == 3) return f.wr_full || f.wr_flush || !f.wr_empty;
      return 0;
   endfunction : exp_wait
   task automatic chk(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   ////////////////////////////////////////////////////////////
   // Watch the answer; FIFO service ends two cycles after start is seen or the search ends, never when hold is set
   task automatic observe(input logic st, input logic w, input logic nw, input int hold);
      logic seen;
      seen = 1'h0;
      for (int i = 0; i < 8 && !seen; i++) begin
         @(posedge clk_in);
         #1;
         seen = (start === 1'h1);
      end
      chk(seen, st);
      if (seen) chk(ready, w);
      if (seen) chk(now, nw);
      repeat (2) @(posedge clk_in);
      #1;
      if (hold == 0) busy = 1'h0;
      repeat (4) @(posedge clk_in);
      #1;
      if (hold != 0) chk(ready, 1'h0);
   endtask : observe
   task automatic run(input int k, input int r, input int s, input int mode);
      int w;
      int d0;
      w = exp_wait(k, r, s, fifo, prev_aw);
      d0 = n_done;
      busy = 1'h1;
      fork
         u_host.access(k[1:0], r[0], s[0], mode);
         observe(mode == 0 || mode == 3, w[0], r[0] && !w[0], mode == 3);
      join
      repeat (5) @(posedge clk_in);
      #1;
      chk(n_done == d0 + ((s[0] && mode == 0) ? 1 : 0), 1'h1);
      if (mode == 0 || mode == 3) prev_aw = (k == 2 && r == 0);
      busy = 1'h0;
      repeat (3) @(posedge clk_in);
      #1;
   endtask : run
   task automatic tally_and_finish();
      if (err_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      err_count = 0;
      n_compared = 0;
      prev_aw = 0;
      rst_b_in = 1'h0;
      busy = 1'h1;
      fifo = hpr_pkg::hpr_fifo_t'(5'h04);
      void'($urandom(32'h796521FD));
      repeat (10) @(posedge clk_in);
      #1;
      rst_b_in = 1'h1;
      run(2, 0, 0, 0);
      run(2, 0, 1, 0);
      fifo = hpr_pkg::hpr_fifo_t'(5'h05);
      run(0, 0, 0, 0);
      run(0, 0, 1, 0);
      run(2, 0, 0, 0);
      run(2, 0, 1, 0);
      run(1, 0, 0, 1);
      run(1, 0, 0, 2);
      fifo = hpr_pkg::hpr_fifo_t'(5'h10);
      run(3, 0, 0, 3);
      // Random pairs of half-words: random kind and direction per pair, random FIFO state per half
      repeat (30) begin
         int k, r;
         k = $urandom % 4;
         r = $urandom % 2;
         for (int s = 0; s < 2; s++) begin
            fifo = hpr_pkg::hpr_fifo_t'(5'($urandom));
            run(k, r, s, 0);
         end
      end
      tally_and_finish();
   end
   ////////////////////////////////////////////////////////////
   // Watchdog, far beyond the expected run of some 1,330 cycles
   initial begin
      #2000000;
      err_count++;
      tally_and_finish();
   end
endmodule : testbench
